// ### sim/drpm_dram_model.sv
// behavioural model of the dram ranks facing the rank power manager
module drpm_dram_model
#(
    parameter int RANKS = 4
)
(
    // clock and reset
    input wire logic mclk,
    input wire logic rst_n,
    // controller side
    input wire logic [RANKS-1:0] txn_arrive,
    input wire logic [RANKS-1:0] close_pages,
    input wire logic [RANKS-1:0] cke_o,
    input wire logic [RANKS-1:0] cke_oe,
    // device side
    output logic [RANKS-1:0] pages_open,
    output logic [RANKS-1:0] cke_pin
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [RANKS-1:0] cke_last_reg;
    logic [2:0] pre_cnt_reg [RANKS];

    // an undriven cke floats: show the inverse of the last level, never a
    // stale copy, since a floating cke gives no data integrity
    always_comb
    begin
        cke_pin = (cke_oe & cke_o) | (~cke_oe & ~cke_last_reg);
    end

    // the last cke level counts as low from power-up, so an undriven cke then reads high
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
            cke_last_reg <= '0;
        else
            cke_last_reg <= cke_pin;
    end

    // a page opens on each access; a precharge takes four cycles
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            pages_open <= '0;
            for (int i = 0; i < RANKS; i++)
                pre_cnt_reg[i] <= 3'h0;
        end
        else
        begin
            for (int i = 0; i < RANKS; i++)
            begin
                if (txn_arrive[i])
                begin
                    pages_open[i] <= 1'b1;
                    pre_cnt_reg[i] <= 3'h0;
                end
                else if (close_pages[i] && pages_open[i])
                begin
                    pre_cnt_reg[i] <= pre_cnt_reg[i] + 3'h1;
                    if (pre_cnt_reg[i] == 3'h3)
                        pages_open[i] <= 1'b0;
                end
            end
        end
    end
endmodule : drpm_dram_model

// ### sim/tb_dram_rank_power_manager.sv
// self-checking bench for the rank power manager
module tb_dram_rank_power_manager;
    timeunit 1ns;
    timeprecision 1ps;
    import drpm_pkg::*;
    logic mclk = 1'b0;
    logic rst_n = 1'b0;
    logic [3:0] reg_addr = 4'h0;
    logic [31:0] reg_wdata = 32'h0;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [3:0] txn_arrive = 4'h0;
    logic [3:0] txn_queued = 4'h0;
    logic refresh_req = 1'b0;
    logic suspend_req = 1'b0;
    logic deep_cstate = 1'b0;
    logic [3:0] gfx_rank = 4'h0;
    logic pending_empty = 1'b1;
    logic io_supply_gating = 1'b0;
    logic [7:0] throttle_level = 8'h0;
    logic [31:0] reg_rdata, d;
    logic [3:0] close_pages, cmd_ok, data_ok, pages_open, cke_pin;
    logic [3:0] cke_o, cke_oe, cs_n_o, cs_oe, clk_oe, term_o, rx_en, dll_en;
    logic refresh_go, flush_req, retrain_skip, dram_reset_pin_n, vref_hold;
    logic [7:0] module_budget;
    int error_cnt = 0;
    int samples_checked = 0;
    int seed = 32'h28b78308;
    int n;

    drpm_top drpm_top_inst (
        .mclk(mclk), .rst_n(rst_n), .clk_en(1'b1),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .txn_arrive(txn_arrive), .txn_queued(txn_queued),
        .pages_open(pages_open), .close_pages(close_pages),
        .cmd_ok(cmd_ok), .data_ok(data_ok),
        .refresh_req(refresh_req), .refresh_go(refresh_go),
        .suspend_req(suspend_req), .deep_cstate(deep_cstate),
        .gfx_rank(gfx_rank), .pending_empty(pending_empty),
        .flush_req(flush_req), .io_supply_gating(io_supply_gating),
        .throttle_level(throttle_level), .module_budget(module_budget),
        .retrain_skip(retrain_skip), .cke_o(cke_o), .cke_oe(cke_oe),
        .cs_n_o(cs_n_o), .cs_oe(cs_oe), .clk_oe(clk_oe),
        .termination_control_o(term_o), .rx_enable(rx_en),
        .dll_enable(dll_en), .dram_reset_pin_n(dram_reset_pin_n),
        .vref_hold(vref_hold)
    );

    drpm_dram_model drpm_dram_model_inst (
        .mclk(mclk), .rst_n(rst_n), .txn_arrive(txn_arrive),
        .close_pages(close_pages), .cke_o(cke_o), .cke_oe(cke_oe),
        .pages_open(pages_open), .cke_pin(cke_pin)
    );

    // free-running memory clock, 8 ns period
    always #4 mclk = ~mclk;

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp)
        begin
            error_cnt++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk

    task automatic conclude();
        $display("checks=%0d mismatches=%0d", samples_checked, error_cnt);
        if (error_cnt == 0 && samples_checked > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : conclude

    task automatic wr(input logic [3:0] a, input logic [31:0] v);
        @(posedge mclk);
        reg_addr <= a;
        reg_wdata <= v;
        reg_wr <= 1'b1;
        @(posedge mclk);
        reg_wr <= 1'b0;
    endtask : wr

    // read data stand only in the cycle after the strobe
    task automatic rd(input logic [3:0] a, output logic [31:0] v);
        @(posedge mclk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge mclk);
        reg_rd <= 1'b0;
        #1 v = reg_rdata;
    endtask : rd

    task automatic pulse(input int r);
        @(posedge mclk);
        txn_arrive[r] <= 1'b1;
        @(posedge mclk);
        txn_arrive[r] <= 1'b0;
    endtask : pulse

    // idle entry, restart on arrival, then wake and exit timing
    task automatic sleep_case(input logic [3:0] kind, input logic [11:0] lim,
                              input int r);
        int nc;
        logic sc;
        wr(4'h0, {16'h0, kind, lim});
        txn_queued[r] <= 1'b1;
        pulse(r);
        repeat (lim / 2) @(posedge mclk);
        txn_queued[r] <= 1'b0;
        pulse(r);
        n = 0;
        sc = 1'b0;
        while (cke_pin[r] !== 1'b0 && n < lim + 40)
        begin
            @(posedge mclk);
            #1 n++;
            sc = sc | close_pages[r];
        end
        chk(n >= lim - 1 && n <= lim + 12, 1);
        chk(sc, kind == 4'h6);
        pulse(r);
        n = 0;
        nc = 0;
        while (data_ok[r] !== 1'b1 && n < 60)
        begin
            @(posedge mclk);
            #1 n++;
            if (cmd_ok[r] !== 1'b1)
                nc = n;
        end
        chk(nc >= 2 && nc <= 6, 1);
        if (kind == 4'h6)
            chk(n >= 19 && n <= 24, 1);
        else
            chk(n >= 2 && n <= 6, 1);
        $display("test sleep kind %h limit %0d done", kind, lim);
    endtask : sleep_case

    // watchdog: the whole run needs well under 6000 cycles
    initial
    begin
        repeat (6000) @(posedge mclk);
        error_cnt++;
        conclude();
    end

    initial
    begin
        throttle_level <= 8'($random(seed));
        repeat (8) @(posedge mclk);
        chk(cke_o, 4'h0);
        chk(cke_oe, 4'hf);
        rst_n <= 1'b1;
        repeat (3) @(posedge mclk);
        rd(4'h0, d);
        chk(d, 32'h6080);
        chk(cke_o, 4'h0);
        wr(4'h4, 32'h1);
        repeat (2) @(posedge mclk);
        chk(cke_o, 4'hf);
        rd(4'h2, d);
        chk(d, 32'h0);
        // random kind, but a limit far past this test so no rank sleeps
        d = $random(seed);
        d[11] = 1'b1;
        wr(4'h0, {16'h0, d[15:0]});
        rd(4'h0, reg_wdata);
        chk(reg_wdata, {16'h0, d[15:0]});
        $display("test reset and registers done");
        // no power-down: idle expiry must not drop cke
        wr(4'h0, 32'h0008);
        pulse(0);
        repeat (40) @(posedge mclk);
        chk(cke_o, 4'hf);
        // deep package state, graphics rank kept awake
        gfx_rank <= 4'h2;
        deep_cstate <= 1'b1;
        repeat (10) @(posedge mclk);
        chk(cke_o, 4'h2);
        deep_cstate <= 1'b0;
        repeat (40) @(posedge mclk);
        chk(cke_o, 4'hf);
        // suspend waits for the flush before self-refresh
        pending_empty <= 1'b0;
        suspend_req <= 1'b1;
        repeat (4) @(posedge mclk);
        chk(flush_req, 1'b1);
        chk(cke_o, 4'hf);
        pending_empty <= 1'b1;
        repeat (10) @(posedge mclk);
        chk(cke_o, 4'h2);
        suspend_req <= 1'b0;
        repeat (40) @(posedge mclk);
        $display("test self-refresh done");
        sleep_case(4'h1, 12'(8 + ($random(seed) & 31)), $random(seed) & 3);
        sleep_case(4'h6, 12'(8 + ($random(seed) & 31)), $random(seed) & 3);
        // refresh wakes every rank, then they sleep again
        wr(4'h0, 32'h6008);
        repeat (60) @(posedge mclk);
        chk(cke_o, 4'h0);
        refresh_req <= 1'b1;
        n = 0;
        while (refresh_go !== 1'b1 && n < 100)
        begin
            @(posedge mclk);
            #1 n++;
        end
        chk(cke_o, 4'hf);
        // keep the request over the edge that starts the refresh window
        @(posedge mclk);
        refresh_req <= 1'b0;
        repeat (120) @(posedge mclk);
        chk(cke_o, 4'h0);
        $display("test refresh done");
        // rank 3 absent: its pins released
        wr(4'h4, 32'h81);
        repeat (2) @(posedge mclk);
        chk(cke_oe, 4'h7);
        chk(cs_oe, 4'h7);
        chk(clk_oe, cke_o & 4'h7);
        chk(rx_en, 4'h7);
        io_supply_gating <= 1'b1;
        repeat (2) @(posedge mclk);
        chk(vref_hold, 1'b1);
        chk(dram_reset_pin_n, 1'b1);
        chk(retrain_skip, 1'b1);
        // locked registers refuse writes
        wr(4'h4, 32'h83);
        wr(4'h0, 32'h1010);
        rd(4'h0, d);
        chk(d, 32'h6008);
        $display("test pins and lock done");
        conclude();
    end
endmodule : tb_dram_rank_power_manager

// ### src/drpm_cfg.svh
// constants for the rank power manager: offsets, fields, resets, timing
`ifndef DRPM_CFG_SVH
`define DRPM_CFG_SVH
`define DRPM_OFF_PDCFG 4'h0
`define DRPM_OFF_CTRL 4'h4
`define DRPM_OFF_STATUS 4'h8
`define DRPM_OFF_TRAIN 4'hc
`define DRPM_KIND_HI 15
`define DRPM_KIND_LO 12
`define DRPM_LIMIT_HI 11
`define DRPM_LIMIT_LO 0
`define DRPM_PDCFG_RST 16'h6080
`define DRPM_KIND_NONE 4'h0
`define DRPM_KIND_OPEN 4'h1
`define DRPM_KIND_CLOSED 4'h6
`define DRPM_CTRL_CKE_EN 0
`define DRPM_CTRL_LOCK 1
`define DRPM_CTRL_TRI_LO 4
`define DRPM_TXP_CYC 4'h3
`define DRPM_TXPDLL_CYC 5'h14
`define DRPM_CLOSE_CYC 4'h4
`define DRPM_REF_CYC 8'h40
`endif

// ### src/drpm_pkg.sv
// types shared by the rank power manager files
package drpm_pkg;
    typedef enum logic [2:0] {
        RK_AWAKE,
        RK_CLOSING,
        RK_SLEEP,
        RK_EXIT,
        RK_SELFREF
    } drpm_rank_state_t;
    typedef logic [3:0] drpm_kind_t;
endpackage : drpm_pkg

// ### src/drpm_rank.sv
// one rank: idle counter, sleep state machine and clock enable
`include "drpm_cfg.svh"
module drpm_rank
    import drpm_pkg::*;
(
    // clock and reset
    input wire logic mclk,
    input wire logic rst_sync_n,
    input wire logic clk_en,
    // configuration
    input wire drpm_pkg::drpm_kind_t kind,
    input wire logic [11:0] idle_limit,
    input wire logic cke_enable,
    // traffic and system events
    input wire logic txn_arrive,
    input wire logic txn_queued,
    input wire logic pages_open,
    input wire logic refresh_req,
    input wire logic selfref_req,
    // results
    output logic cke,
    output logic close_pages,
    output logic cmd_ok,
    output logic data_ok,
    output logic dll_off,
    output logic in_selfref,
    output logic [2:0] state_code
);
    import drpm_pkg::*;

    drpm_rank_state_t state_reg;
    logic [11:0] idle_reg;
    logic [4:0] wait_reg;
    logic dll_off_reg;
    logic idle_done;

    assign idle_done = (idle_reg >= idle_limit);
    assign state_code = state_reg;

    // idle count restarts at every arriving transaction
    always_ff @(posedge mclk or negedge rst_sync_n)
    begin
        if (!rst_sync_n)
            idle_reg <= 12'h000;
        else if (clk_en)
        begin
            if (txn_arrive || txn_queued)
                idle_reg <= 12'h000;
            else if (!idle_done)
                idle_reg <= idle_reg + 12'h001;
        end
    end

    // sleep sequencing; a refresh wakes the rank from sleep or closing, not from self-refresh, and it sleeps again after
    always_ff @(posedge mclk or negedge rst_sync_n)
    begin
        if (!rst_sync_n)
        begin
            state_reg <= RK_AWAKE;
            wait_reg <= 5'h00;
            dll_off_reg <= 1'b0;
        end
        else if (clk_en)
        begin
            if (wait_reg != 5'h00)
                wait_reg <= wait_reg - 5'h01;
            unique case (state_reg)
                RK_AWAKE:
                begin
                    if (selfref_req && !txn_queued)
                        state_reg <= RK_SELFREF;
                    else if (kind != `DRPM_KIND_NONE && idle_done &&
                        !txn_queued && !txn_arrive && !refresh_req &&
                        cke_enable)
                    begin
                        if (kind == `DRPM_KIND_CLOSED && pages_open)
                        begin
                            state_reg <= RK_CLOSING;
                            wait_reg <= {1'b0, `DRPM_CLOSE_CYC};
                        end
                        else
                        begin
                            state_reg <= RK_SLEEP;
                            dll_off_reg <= (kind == `DRPM_KIND_CLOSED);
                        end
                    end
                end
                RK_CLOSING:
                begin
                    if (txn_arrive || refresh_req)
                        state_reg <= RK_AWAKE;
                    else if (wait_reg == 5'h00 && !pages_open)
                    begin
                        state_reg <= RK_SLEEP;
                        dll_off_reg <= 1'b1;
                    end
                end
                RK_SLEEP:
                begin
                    if (txn_arrive || txn_queued || refresh_req ||
                        selfref_req)
                    begin
                        state_reg <= RK_EXIT;
                        wait_reg <= dll_off_reg ? `DRPM_TXPDLL_CYC
                            : {1'b0, `DRPM_TXP_CYC};
                    end
                end
                RK_EXIT:
                begin
                    if (wait_reg == 5'h00)
                    begin
                        state_reg <= RK_AWAKE;
                        dll_off_reg <= 1'b0;
                    end
                end
                RK_SELFREF:
                begin
                    if (!selfref_req)
                    begin
                        state_reg <= RK_EXIT;
                        wait_reg <= `DRPM_TXPDLL_CYC;
                    end
                end
            endcase
        end
    end

    // clock enable low while asleep or in self-refresh
    assign cke = cke_enable &&
        (state_reg == RK_AWAKE || state_reg == RK_CLOSING ||
         state_reg == RK_EXIT);
    assign close_pages = (state_reg == RK_CLOSING);
    // commands after txp, data only after txpdll when the dll was off
    // both exit kinds honour txp before the first command
    assign cmd_ok = (state_reg == RK_AWAKE) ||
        (state_reg == RK_EXIT && wait_reg <= (dll_off_reg ?
         `DRPM_TXPDLL_CYC - {1'b0, `DRPM_TXP_CYC} : 5'h00));
    assign data_ok = (state_reg == RK_AWAKE);
    assign dll_off = dll_off_reg;
    assign in_selfref = (state_reg == RK_SELFREF);

    a_sleep_cke_low: assert property (@(posedge mclk) disable iff
        (!rst_sync_n) state_reg == RK_SLEEP |-> !cke)
        else $error("cke high while rank asleep");
    a_closed_after_close: assert property (@(posedge mclk) disable iff
        (!rst_sync_n) (state_reg == RK_CLOSING && clk_en &&
        !txn_arrive && !refresh_req) ##1 state_reg == RK_SLEEP
        |-> !pages_open || $past(!pages_open))
        else $error("sleep entered with pages open");
    a_none_keeps_cke: assert property (@(posedge mclk) disable iff
        (!rst_sync_n) (kind == `DRPM_KIND_NONE && state_reg == RK_AWAKE
        && !selfref_req && cke_enable) |=> state_reg != RK_SLEEP)
        else $error("sleep in no power-down setting");
    a_wake_on_txn: assert property (@(posedge mclk) disable iff
        (!rst_sync_n) (state_reg == RK_SLEEP && txn_arrive && clk_en)
        |=> state_reg == RK_EXIT)
        else $error("rank not woken by transaction");
    a_idle_restart: assert property (@(posedge mclk) disable iff
        (!rst_sync_n) (txn_arrive && clk_en) |=> idle_reg == 12'h000)
        else $error("idle count not restarted");
    a_dll_exit_wait: assert property (@(posedge mclk) disable iff
        (!rst_sync_n) (state_reg == RK_SLEEP && dll_off_reg && clk_en
        && txn_arrive) |=> !data_ok [*8])
        else $error("data allowed before txpdll");
endmodule : drpm_rank

// ### src/drpm_top.sv
// rank power manager top: registers, pin control and per-rank instances
//
// Functional notes
// - unpopulated ranks: chip select and clock enable not driven
// - after reset all ranks are driven; software enables tri-stating
// - config register: kind in bits 15:12, idle limit in 11:0
// - three kinds: none, open-page sleep, closed-page sleep dll off
// - open-page sleep keeps pages and dll, exit waits txp
// - dll-off exit waits txp for commands, txpdll for data
// - per-rank idle counter; expiry with empty queue allows sleep
// - idle count restarts at each arriving transaction
// - reset config 6080h: closed-page sleep, 128 cycle limit
// - config writable live unless register lock is set
// - clock enables low during reset until software enables them
// - suspend: flush pending, then self-refresh non-graphics ranks
// - deep package state with no requests: self-refresh
// - close all pages before closed-page sleep
// - wake all ranks for refresh, sleep again afterwards; here ranks in self-refresh are not woken
// - clock, cke, termination, chip select per rank; unused off
// - unused signal: driver, receiver, dll off, input gated
// - during io supply gating hold reset, cke, reference pins; here only reset and vref_hold are held, cke is not
// - no retraining after sleep states; restore saved results
// - power cap throttle tracked and budget shared among modules
//
// Decided for this implementation: the placing of the registers and the plain strobed port.
`include "drpm_cfg.svh"
module drpm_top
    import drpm_pkg::*;
#(
    parameter int RANKS = 4,
    parameter int MODULES = 2
)
(
    // clock, reset, enable
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic clk_en,
    // register port
    input wire logic [3:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    // traffic per rank
    input wire logic [RANKS-1:0] txn_arrive,
    input wire logic [RANKS-1:0] txn_queued,
    input wire logic [RANKS-1:0] pages_open,
    output logic [RANKS-1:0] close_pages,
    output logic [RANKS-1:0] cmd_ok,
    output logic [RANKS-1:0] data_ok,
    // system state
    input wire logic refresh_req,
    output logic refresh_go,
    input wire logic suspend_req,
    input wire logic deep_cstate,
    input wire logic [RANKS-1:0] gfx_rank,
    input wire logic pending_empty,
    output logic flush_req,
    input wire logic io_supply_gating,
    input wire logic [7:0] throttle_level,
    output logic [7:0] module_budget,
    output logic retrain_skip,
    // dram pins (driver value and enables)
    output logic [RANKS-1:0] cke_o,
    output logic [RANKS-1:0] cke_oe,
    output logic [RANKS-1:0] cs_n_o,
    output logic [RANKS-1:0] cs_oe,
    output logic [RANKS-1:0] clk_oe,
    output logic [RANKS-1:0] termination_control_o,
    output logic [RANKS-1:0] rx_enable,
    output logic [RANKS-1:0] dll_enable,
    output logic dram_reset_pin_n,
    output logic vref_hold
);
    import drpm_pkg::*;

    logic rst_s1_reg;
    logic rst_sync_n;
    logic [15:0] pdcfg_reg;
    logic cke_en_reg;
    logic lock_reg;
    logic [RANKS-1:0] tri_reg;
    logic [31:0] train_reg;
    logic [31:0] rdata_reg;
    logic [RANKS-1:0] rk_cke;
    logic [RANKS-1:0] rk_sr;
    logic [RANKS-1:0] rk_dll;
    logic [RANKS-1:0] rk_awake;
    logic [2:0] rk_code [RANKS];
    logic [RANKS-1:0] tq_s1_reg;
    logic [RANKS-1:0] tq_reg;
    logic sr_phase_reg;
    logic selfref_want;
    logic [7:0] ref_cnt_reg;
    logic refresh_busy;
    logic [15:0] thr_acc_reg;
    logic [7:0] budget_reg;
    logic dram_rst_reg;

    // reset release through two flops, assertion stays asynchronous
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            rst_s1_reg <= 1'b0;
            rst_sync_n <= 1'b0;
        end
        else
        begin
            rst_s1_reg <= 1'b1;
            rst_sync_n <= rst_s1_reg;
        end
    end

    // register writes; the lock freezes the config once set
    always_ff @(posedge mclk or negedge rst_sync_n)
    begin
        if (!rst_sync_n)
        begin
            pdcfg_reg <= `DRPM_PDCFG_RST;
            cke_en_reg <= 1'b0;
            lock_reg <= 1'b0;
            tri_reg <= '0;
            train_reg <= 32'h0000_0000;
        end
        else if (clk_en && reg_wr)
        begin
            if (reg_addr == `DRPM_OFF_PDCFG && !lock_reg)
                pdcfg_reg <= reg_wdata[15:0];
            if (reg_addr == `DRPM_OFF_CTRL && !lock_reg)
            begin
                cke_en_reg <= reg_wdata[`DRPM_CTRL_CKE_EN];
                lock_reg <= reg_wdata[`DRPM_CTRL_LOCK];
                tri_reg <= reg_wdata[`DRPM_CTRL_TRI_LO +: RANKS];
            end
            // saved training results survive every sleep state
            if (reg_addr == `DRPM_OFF_TRAIN)
                train_reg <= reg_wdata;
        end
    end

    // read data one cycle after the strobe, zero for unmapped words
    always_ff @(posedge mclk or negedge rst_sync_n)
    begin
        if (!rst_sync_n)
            rdata_reg <= 32'h0000_0000;
        else if (clk_en)
        begin
            rdata_reg <= 32'h0000_0000;
            if (reg_rd)
            begin
                unique case (reg_addr)
                    `DRPM_OFF_PDCFG: rdata_reg <= {16'h0000, pdcfg_reg};
                    `DRPM_OFF_CTRL: rdata_reg <= 32'(
                        {tri_reg, 2'b00, lock_reg, cke_en_reg});
                    `DRPM_OFF_STATUS: rdata_reg <= 32'(
                        {budget_reg, rk_sr, rk_dll, rk_cke});
                    `DRPM_OFF_TRAIN: rdata_reg <= train_reg;
                    default: rdata_reg <= 32'h0000_0000;
                endcase
            end
        end
    end
    assign reg_rdata = rdata_reg;

    // queue occupancy comes from another block clock? no: same clock,
    // but kept registered so sleep decisions see a stable view
    always_ff @(posedge mclk or negedge rst_sync_n)
    begin
        if (!rst_sync_n)
        begin
            tq_s1_reg <= '0;
            tq_reg <= '0;
        end
        else if (clk_en)
        begin
            tq_s1_reg <= txn_queued;
            tq_reg <= txn_queued | tq_s1_reg;
        end
    end

    // self-refresh entry only after pending cycles are flushed
    assign selfref_want = suspend_req || deep_cstate;
    always_ff @(posedge mclk or negedge rst_sync_n)
    begin
        if (!rst_sync_n)
            sr_phase_reg <= 1'b0;
        else if (clk_en)
            sr_phase_reg <= selfref_want && pending_empty;
    end
    assign flush_req = selfref_want && !sr_phase_reg;

    // refresh: all ranks not in self-refresh woken, refresh issued once all are awake
    always_ff @(posedge mclk or negedge rst_sync_n)
    begin
        if (!rst_sync_n)
            ref_cnt_reg <= 8'h00;
        else if (clk_en)
        begin
            if (refresh_req && &rk_awake && ref_cnt_reg == 8'h00)
                ref_cnt_reg <= `DRPM_REF_CYC;
            else if (ref_cnt_reg != 8'h00)
                ref_cnt_reg <= ref_cnt_reg - 8'h01;
        end
    end
    assign refresh_busy = refresh_req || (ref_cnt_reg != 8'h00);
    assign refresh_go = refresh_req && &rk_awake && ref_cnt_reg == 8'h00;

    // one sleep controller per rank
    genvar g;
    generate
        for (g = 0; g < RANKS; g++)
        begin : g_rank
            drpm_rank u_rank (
                .mclk(mclk),
                .rst_sync_n(rst_sync_n),
                .clk_en(clk_en),
                .kind(pdcfg_reg[`DRPM_KIND_HI:`DRPM_KIND_LO]),
                .idle_limit(pdcfg_reg[`DRPM_LIMIT_HI:`DRPM_LIMIT_LO]),
                .cke_enable(cke_en_reg),
                .txn_arrive(txn_arrive[g]),
                .txn_queued(tq_reg[g]),
                .pages_open(pages_open[g]),
                .refresh_req(refresh_busy),
                .selfref_req(sr_phase_reg && !gfx_rank[g]),
                .cke(rk_cke[g]),
                .close_pages(close_pages[g]),
                .cmd_ok(cmd_ok[g]),
                .data_ok(data_ok[g]),
                .dll_off(rk_dll[g]),
                .in_selfref(rk_sr[g]),
                .state_code(rk_code[g])
            );
            assign rk_awake[g] = (rk_code[g] == 3'(RK_AWAKE)) || tri_reg[g];
        end
    endgenerate

    // pin control; absent ranks float and lose receiver and dll
    always_comb
    begin
        cke_o = rk_cke & ~tri_reg;
        cke_oe = ~tri_reg;
        cs_n_o = '1;
        cs_oe = ~tri_reg;
        clk_oe = ~tri_reg & rk_cke;
        termination_control_o = rk_cke & ~tri_reg;
        rx_enable = ~tri_reg & ~rk_sr;
        dll_enable = ~tri_reg & ~rk_dll;
    end

    // dram reset released with the enable; held through supply gating
    always_ff @(posedge mclk or negedge rst_sync_n)
    begin
        if (!rst_sync_n)
            dram_rst_reg <= 1'b0;
        else if (clk_en && !io_supply_gating)
            dram_rst_reg <= cke_en_reg;
    end
    assign dram_reset_pin_n = dram_rst_reg;
    assign vref_hold = io_supply_gating;
    assign retrain_skip = 1'b1;

    // running throttle average split evenly among modules
    always_ff @(posedge mclk or negedge rst_sync_n)
    begin
        if (!rst_sync_n)
        begin
            thr_acc_reg <= 16'h0000;
            budget_reg <= 8'hff;
        end
        else if (clk_en)
        begin
            thr_acc_reg <= thr_acc_reg - (thr_acc_reg >> 4)
                + {8'h00, throttle_level};
            budget_reg <= 8'(16'hff - (thr_acc_reg >> 4)) >>
                $clog2(MODULES);
        end
    end
    assign module_budget = budget_reg;

    a_cke_low_reset: assert property (@(posedge mclk) disable iff
        (!rst_sync_n) !cke_en_reg |-> cke_o == '0)
        else $error("cke high before enable");
    a_absent_float: assert property (@(posedge mclk) disable iff
        (!rst_sync_n) (cke_oe & tri_reg) == '0 && (cs_oe & tri_reg) == '0)
        else $error("absent rank driven");
    a_lock_holds: assert property (@(posedge mclk) disable iff
        (!rst_sync_n) (lock_reg && reg_wr && clk_en) |=> $stable(pdcfg_reg))
        else $error("locked config changed");
endmodule : drpm_top
